// *** include/sdmra_pkg.sv ***
// Functional notes
// - only NOPs during the two-cycle window after a register read
// - thermal status register holds sensor status in bits 2:0
// - thermal status refreshed internally within the 32 ms interval
// - thermal status fresh on leaving self refresh or power-down
// - calibration registers return patterns 1,0,1,0 and 0,0,1,1
// - pattern on lane 0 of every byte for the whole burst
// - other lanes of each byte copy lane 0
// - register read is a four-beat burst, never interrupted; here a read command issued before the burst ends restarts it
// - write decode: CS_n and CA3..CA0 low; address and data from CA
// - writes to read-only registers change nothing
// - reads allowed with banks active or idle; bank state unchanged
// - reset write restores defaults, auto-init with NOP-only wait
// - array contents undefined after the reset write completes
// - read decode: CS_n, CA2..CA0 low and CA3 high
// - register value on DQ 7:0 in first beat after read latency
// - register read command window lasts two cycles
package sdmra_pkg;
  localparam int CLOCK_KHZ             = 50_000;
  localparam int THERMAL_INTERVAL_MS   = 32;
  localparam int THERMAL_UPDATE_CYCLES = THERMAL_INTERVAL_MS * CLOCK_KHZ;
  localparam int READ_CMD_PERIOD       = 2;
  localparam int BURST_BEATS           = 4;
  localparam int WRITE_CMD_CYCLES      = 5;
  localparam int INIT_WAIT_CYCLES      = 16;
  localparam int READ_LATENCY          = 3;
  localparam int THERMAL_MSB           = 2;
  localparam logic [3:0] CMD_REG_WRITE = 4'h0;
  localparam logic [3:0] CMD_REG_READ  = 4'h8;
  localparam logic [2:0] CA_NOP        = 3'h7;
  localparam logic [7:0] THERMAL_ADDR  = 8'h04;
  localparam logic [7:0] CAL_A_ADDR    = 8'h20;
  localparam logic [7:0] CAL_B_ADDR    = 8'h28;
  localparam logic [7:0] RESET_ADDR    = 8'h3f;
  localparam logic [7:0] REG_DEFAULT   = 8'h00;
  localparam logic [3:0] CAL_PATTERN_A = 4'h5;
  localparam logic [3:0] CAL_PATTERN_B = 4'hc;
  typedef enum {ST_IDLE, ST_RD, ST_WR, ST_INIT} sdmra_state_type;
endpackage : sdmra_pkg

// *** rtl/sdmra_core.sv ***
`timescale 1ns/1ps
`default_nettype none
module sdmra_core
  import sdmra_pkg::*;
#(
  parameter int DQ_WIDTH       = 32,
  parameter int RD_LATENCY     = READ_LATENCY,
  parameter int WR_CYCLES      = WRITE_CMD_CYCLES,
  parameter int INIT_CYCLES    = INIT_WAIT_CYCLES,
  parameter int THERMAL_CYCLES = THERMAL_UPDATE_CYCLES
) (
  input  wire logic                clock,
  input  wire logic                arst_n,
  input  wire logic                cs_n,
  input  wire logic [9:0]          ca_rise,
  input  wire logic [9:0]          ca_fall,
  input  wire logic                bank_active,
  input  wire logic [2:0]          temp_code,
  input  wire logic                lp_exit,
  output logic      [DQ_WIDTH-1:0] dq_out,
  output logic                     dq_oe,
  output logic                     dqs_toggle,
  output logic                     cmd_rejected,
  output logic                     init_busy,
  output logic                     array_undefined
);
  // ************************************************************
  // parameter checks
  // ************************************************************
  if (!(DQ_WIDTH == 16 || DQ_WIDTH == 32)) begin : g_bad_width
    $error("dq width must be 16 or 32");
  end
  if (RD_LATENCY < 1 || RD_LATENCY + BURST_BEATS > 255) begin : g_bad_rl
    $error("read latency out of range");
  end
  if (WR_CYCLES < 1 || INIT_CYCLES < 1 || WR_CYCLES > 65535
      || INIT_CYCLES > 65535) begin : g_bad_win
    $error("window length out of range");
  end
  if (THERMAL_CYCLES < 2 || THERMAL_CYCLES > THERMAL_UPDATE_CYCLES)
  begin : g_bad_tsi
    $error("thermal interval out of range");
  end

  // ************************************************************
  // command decode
  // ************************************************************
  sdmra_state_type st;
  logic [15:0]     win_cnt;
  logic [7:0]      mode_reg [256];
  logic [2:0]      thermal;
  logic [20:0]     tsi_cnt;
  logic [7:0]      rd_addr;
  logic [7:0]      rd_cnt;
  logic            is_rd_cmd;
  logic            is_wr_cmd;
  logic            is_nop;
  logic            is_ro;
  logic [7:0]      ma;
  logic [7:0]      wdata;
  logic            rd_go;
  logic            wr_go;
  logic            rst_go;
  logic            idle;

  assign is_rd_cmd = !cs_n && ca_rise[3:0] == CMD_REG_READ;
  assign is_wr_cmd = !cs_n && ca_rise[3:0] == CMD_REG_WRITE;
  assign is_nop = cs_n || ca_rise[2:0] == CA_NOP;
  assign ma     = {ca_rise[9:4], ca_fall[1:0]};
  assign wdata  = ca_fall[9:2];
  assign is_ro  = ma == THERMAL_ADDR || ma == CAL_A_ADDR || ma == CAL_B_ADDR;
  assign idle   = st == ST_IDLE;
  // reads are taken with or without open banks; no bank state is touched
  assign rd_go  = idle && is_rd_cmd;
  assign wr_go  = idle && is_wr_cmd && !bank_active && ma != RESET_ADDR;
  assign rst_go = idle && is_wr_cmd && !bank_active && ma == RESET_ADDR;

  // ************************************************************
  // command windows
  // ************************************************************
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      st      <= ST_IDLE;
      win_cnt <= 16'h0000;
    end else begin
      case (st)
        ST_IDLE: begin
          if (rd_go) begin
            st      <= ST_RD;
            win_cnt <= 16'(READ_CMD_PERIOD - 2);
          end else if (wr_go) begin
            st      <= ST_WR;
            win_cnt <= 16'(WR_CYCLES - 1);
          end else if (rst_go) begin
            st      <= ST_INIT;
            win_cnt <= 16'(INIT_CYCLES - 1);
          end
        end
        ST_RD, ST_WR, ST_INIT: begin
          if (win_cnt == 16'h0000) begin
            st <= ST_IDLE;
          end else begin
            win_cnt <= win_cnt - 16'h0001;
          end
        end
        default: st <= ST_IDLE;
      endcase
    end
  end

  // non-NOP inside a window, or a write with open banks, is dropped
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cmd_rejected <= 1'b0;
    end else begin
      cmd_rejected <= (!idle && !is_nop)
                      || (idle && is_wr_cmd && bank_active);
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      init_busy       <= 1'b0;
      array_undefined <= 1'b0;
    end else begin
      init_busy <= rst_go || (st == ST_INIT && win_cnt != 16'h0000);
      // sticky until power-on reset: nothing here restores the array
      if (st == ST_INIT && win_cnt == 16'h0000) begin
        array_undefined <= 1'b1;
      end
    end
  end

  // ************************************************************
  // mode registers
  // ************************************************************
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < 256; i++) begin
        mode_reg[i] <= REG_DEFAULT;
      end
    end else if (rst_go) begin
      for (int i = 0; i < 256; i++) begin
        mode_reg[i] <= REG_DEFAULT;
      end
    end else if (wr_go && !is_ro) begin
      mode_reg[ma] <= wdata;
    end
  end

  // ************************************************************
  // thermal status
  // ************************************************************
  // sampled on a fixed period no longer than the interval, and again on
  // low-power exit so a stale value never survives a sleep
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      thermal <= 3'h0;
      tsi_cnt <= 21'h00_0000;
    end else if (lp_exit || tsi_cnt == 21'h00_0000) begin
      thermal <= temp_code[THERMAL_MSB:0];
      tsi_cnt <= 21'(THERMAL_CYCLES - 1);
    end else begin
      tsi_cnt <= tsi_cnt - 21'h00_0001;
    end
  end

  // ************************************************************
  // read burst
  // ************************************************************
  logic            cal_rd;
  logic [3:0]      cal_pat;
  logic [2:0]      beat;
  logic [7:0]      rd_val;

  assign cal_rd  = rd_addr == CAL_A_ADDR || rd_addr == CAL_B_ADDR;
  assign cal_pat = (rd_addr == CAL_A_ADDR) ? CAL_PATTERN_A : CAL_PATTERN_B;
  assign beat    = 3'(BURST_BEATS) - rd_cnt[2:0];
  assign rd_val  = (rd_addr == THERMAL_ADDR) ? {5'h00, thermal}
                                             : mode_reg[rd_addr];

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rd_addr <= 8'h00;
      rd_cnt  <= 8'h00;
    end else if (rd_go) begin
      rd_addr <= ma;
      rd_cnt  <= 8'(RD_LATENCY + BURST_BEATS - 1);
    end else if (rd_cnt != 8'h00) begin
      rd_cnt <= rd_cnt - 8'h01;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      dq_out     <= '0;
      dq_oe      <= 1'b0;
      dqs_toggle <= 1'b0;
    end else if (rd_cnt != 8'h00 && rd_cnt <= 8'(BURST_BEATS)) begin
      dq_oe      <= 1'b1;
      dqs_toggle <= !dqs_toggle;
      if (cal_rd) begin
        dq_out <= {DQ_WIDTH{cal_pat[beat[1:0]]}};
      end else if (beat == 3'h0) begin
        dq_out <= {{(DQ_WIDTH-8){1'b0}}, rd_val};
      end else begin
        dq_out <= '0;
      end
    end else begin
      dq_out     <= '0;
      dq_oe      <= 1'b0;
      dqs_toggle <= 1'b0;
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  // a beat launched at edge n is first sampled at edge n+1
  localparam int RD_DELAY = RD_LATENCY + 1;

  a_burst_four_beats: assert property (
    @(posedge clock) disable iff (!arst_n)
    rd_go |-> ##RD_DELAY dq_oe [*4] ##1 !dq_oe)
    else $error("read burst not four beats");

  a_first_beat_value: assert property (
    @(posedge clock) disable iff (!arst_n)
    rd_go && ma == THERMAL_ADDR && !lp_exit && tsi_cnt > 21'h00_0010
    |-> ##RD_DELAY dq_out[7:0] == {5'h00, thermal})
    else $error("thermal value missing on first beat");

  a_cal_pattern_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    rd_go && ma == CAL_A_ADDR
    |-> ##RD_DELAY dq_out[0] ##1 !dq_out[0] ##1 dq_out[0] ##1 !dq_out[0])
    else $error("pattern a wrong");

  a_cal_pattern_b: assert property (
    @(posedge clock) disable iff (!arst_n)
    rd_go && ma == CAL_B_ADDR
    |-> ##RD_DELAY !dq_out[0] ##1 !dq_out[0] ##1 dq_out[0] ##1 dq_out[0])
    else $error("pattern b wrong");

  a_cal_lane_copy: assert property (
    @(posedge clock) disable iff (!arst_n)
    dq_oe && $past(cal_rd) |-> dq_out == {DQ_WIDTH{dq_out[0]}})
    else $error("calibration lanes differ");

  a_read_window: assert property (
    @(posedge clock) disable iff (!arst_n)
    rd_go |=> st == ST_RD ##1 st == ST_IDLE)
    else $error("read window not two cycles");

  a_nop_only_window: assert property (
    @(posedge clock) disable iff (!arst_n)
    st != ST_IDLE && !is_nop |=> cmd_rejected)
    else $error("command in window not rejected");

  a_reg_write_store: assert property (
    @(posedge clock) disable iff (!arst_n)
    wr_go && !is_ro |=> mode_reg[$past(ma)] == $past(wdata))
    else $error("register write lost");

  a_reset_init: assert property (
    @(posedge clock) disable iff (!arst_n)
    rst_go |=> init_busy && mode_reg[8'h01] == REG_DEFAULT)
    else $error("reset write did not start init");

  a_thermal_fresh: assert property (
    @(posedge clock) disable iff (!arst_n)
    lp_exit |=> thermal == $past(temp_code))
    else $error("thermal stale after exit");

  a_thermal_period: assert property (
    @(posedge clock) disable iff (!arst_n)
    tsi_cnt == 21'h00_0000 |=> thermal == $past(temp_code))
    else $error("thermal interval exceeded");

  a_undef_after_init: assert property (
    @(posedge clock) disable iff (!arst_n)
    $fell(init_busy) |-> ##1 array_undefined)
    else $error("array not marked undefined");

  c_cal_read:     cover property (@(posedge clock) rd_go && ma == CAL_A_ADDR);
  c_active_read:  cover property (@(posedge clock) rd_go && bank_active);
  c_reg_write:    cover property (@(posedge clock) wr_go && !is_ro);
  c_reset_write:  cover property (@(posedge clock) rst_go);
endmodule : sdmra_core
`default_nettype wire

// *** bench/sdmra_ctrl_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****
// controller model on the command/address bus
// ****
module sdmra_ctrl_model
  import sdmra_pkg::*;
(
  input  wire logic       clock,
  output logic            cs_n,
  output logic [9:0]      ca_rise,
  output logic [9:0]      ca_fall
);
  initial begin
    cs_n    = 1'b1;
    ca_rise = 10'h3ff;
    ca_fall = 10'h3ff;
  end
  // caller is at a falling edge; one command edge, then nops for gap cycles
  // gap 0 leaves the bus to the caller's next command, so no double drive
  // released ca shows the inverse so stale bits never pass for a command
  task automatic issue(input logic [3:0] op, input logic [7:0] addr,
                       input logic [7:0] data, input int gap);
    cs_n    = 1'b0;
    ca_rise = {addr[7:2], op};
    ca_fall = {data, addr[1:0]};
    @(negedge clock);
    if (gap > 0) begin
      cs_n    = 1'b1;
      ca_rise = ~ca_rise;
      ca_fall = ~ca_fall;
    end
    repeat (gap) @(negedge clock);
  endtask : issue
endmodule : sdmra_ctrl_model
`default_nettype wire

// *** bench/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import sdmra_pkg::*;
;
  logic        clock;
  logic        arst_n;
  logic        cs_n;
  logic [9:0]  ca_rise;
  logic [9:0]  ca_fall;
  logic        bank_active;
  logic [2:0]  temp_code;
  logic        lp_exit;
  logic [31:0] dq_out;
  logic        dq_oe;
  logic        dqs_toggle;
  logic        exp_dqs = 1'b1;
  logic        cmd_rejected;
  logic        init_busy;
  logic        array_undefined;
  logic [31:0] exp_q[$];
  logic [7:0]  d;
  logic [2:0]  t;
  logic [7:0]  addr_tab[3] = '{8'h01, 8'h02, 8'h11};
  int          failures = 0;
  int          samples_checked = 0;
  int          rejects = 0;
  int          cycles = 0;

  // ****
  // design and controller
  // ****
  // short thermal interval keeps the run brief
  sdmra_core #(.DQ_WIDTH(32), .THERMAL_CYCLES(50)) i_dut (
    .clock(clock), .arst_n(arst_n), .cs_n(cs_n), .ca_rise(ca_rise),
    .ca_fall(ca_fall), .bank_active(bank_active), .temp_code(temp_code),
    .lp_exit(lp_exit), .dq_out(dq_out), .dq_oe(dq_oe),
    .dqs_toggle(dqs_toggle),
    .cmd_rejected(cmd_rejected), .init_busy(init_busy),
    .array_undefined(array_undefined));
  sdmra_ctrl_model i_ctrl (
    .clock(clock), .cs_n(cs_n), .ca_rise(ca_rise), .ca_fall(ca_fall));

  // ****
  // checking
  // ****
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    samples_checked++;
    if (seen !== want) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : check

  task automatic finish_test;
    if (failures == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : finish_test

  task automatic rd(input logic [7:0] a, input logic [31:0] b0, b1, b2,
                    input logic [31:0] b3, input int g);
    exp_q.push_back(b0);
    exp_q.push_back(b1);
    exp_q.push_back(b2);
    exp_q.push_back(b3);
    i_ctrl.issue(CMD_REG_READ, a, 8'($urandom), g);
  endtask : rd

  // beats are compared in order; a beat nobody expected is a mismatch
  always @(negedge clock) begin
    if (dq_oe !== 1'b1) begin
      exp_dqs = 1'b1;
    end
    if (dq_oe === 1'b1) begin
      check(32'(dqs_toggle), 32'(exp_dqs));
      exp_dqs = ~exp_dqs;
      if (exp_q.size() > 0) begin
        check(dq_out, exp_q.pop_front());
      end else begin
        check(32'h0000_0001, 32'h0000_0000);
      end
    end
    if (cmd_rejected === 1'b1) begin
      rejects++;
    end
  end

  always @(posedge clock) begin
    cycles++;
    if (cycles == 2000) begin
      failures++;
      finish_test();
    end
  end

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // ****
  // scenarios
  // ****
  initial begin
    arst_n      = 1'b0;
    bank_active = 1'b0;
    lp_exit     = 1'b0;
    temp_code   = 3'h0;
    void'($urandom(32'h25b5));
    repeat (12) @(posedge clock);
    @(negedge clock);
    arst_n = 1'b1;
    foreach (addr_tab[i]) begin
      d = 8'($urandom);
      i_ctrl.issue(CMD_REG_WRITE, addr_tab[i], d, 5);
      bank_active = 1'($urandom);
      rd(addr_tab[i], {24'h0, d}, '0, '0, '0, 7);
      bank_active = 1'b0;
    end
    bank_active = 1'b1;
    i_ctrl.issue(CMD_REG_WRITE, 8'h11, ~d, 5);
    bank_active = 1'b0;
    check(32'(rejects), 32'h0000_0001);
    rd(8'h11, {24'h0, d}, '0, '0, '0, 0);
    i_ctrl.issue(CMD_REG_WRITE, 8'h11, ~d, 7);
    check(32'(rejects), 32'h0000_0002);
    i_ctrl.issue(CMD_REG_WRITE, 8'h11, ~d, 1);
    i_ctrl.issue(CMD_REG_READ, 8'h11, 8'h00, 5);
    check(32'(rejects), 32'h0000_0003);
    rd(8'h11, {24'h0, ~d}, '0, '0, '0, 7);
    t = 3'($urandom);
    temp_code = t;
    lp_exit = 1'b1;
    @(negedge clock);
    lp_exit = 1'b0;
    rd(THERMAL_ADDR, {29'h0, t}, '0, '0, '0, 7);
    i_ctrl.issue(CMD_REG_WRITE, THERMAL_ADDR, 8'hff, 5);
    rd(THERMAL_ADDR, {29'h0, t}, '0, '0, '0, 7);
    temp_code = ~t;
    repeat (60) @(negedge clock);
    rd(THERMAL_ADDR, {29'h0, ~t}, '0, '0, '0, 7);
    rd(CAL_A_ADDR, '1, '0, '1, '0, 7);
    rd(CAL_B_ADDR, '0, '0, '1, '1, 7);
    i_ctrl.issue(CMD_REG_WRITE, RESET_ADDR, 8'($urandom), 0);
    check(32'(init_busy), 32'h0000_0001);
    i_ctrl.issue(CMD_REG_READ, 8'h01, 8'h00, 20);
    check(32'(rejects), 32'h0000_0004);
    check(32'(init_busy), 32'h0000_0000);
    check(32'(array_undefined), 32'h0000_0001);
    rd(8'h11, 32'h0000_0000, '0, '0, '0, 7);
    check(32'(exp_q.size()), 32'h0000_0000);
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
